// >>> dv/scm_assertions.sv
// Purpose: Concurrent checks on the engine ports
// Assumes: Bound to every engine instance
// Notes: Only the core clock domain is watched
`timescale 1ns/1ps

module scm_assertions #(
  parameter int TCONV_4096_NS = 8220000 // Longest conversion time
) (
  input wire logic MCLK_I, // Core clock
  input wire logic RESET_N_I, // Reset, active low
  input wire logic SCL_I, // Bus clock
  input wire logic SDA_O, // Drive value
  input wire logic SDA_OE_O, // Data pull enable
  input wire logic BUSY_O, // Conversion running
  input wire logic RESULT_VALID_O // Result held
);
  localparam int MAX_CYC = TCONV_4096_NS / 4 + 8; // Busy length ceiling
  int next_busy_cnt; // Next busy length
  int busy_cnt; // Busy length so far
  // Count the cycles of one conversion
  always_comb begin
    next_busy_cnt = BUSY_O ? busy_cnt + 1 : 0;
  end
  always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      busy_cnt <= 0;
    end else begin
      busy_cnt <= next_busy_cnt;
    end
  end
  default clocking @(posedge MCLK_I);
  endclocking
  default disable iff (!RESET_N_I);
  sequence s_ack_up;
    $rose(SDA_OE_O);
  endsequence
  sequence s_conv_up;
    $rose(BUSY_O);
  endsequence
  property p_drive_low;
    SDA_O == 1'b0;
  endproperty
  a_drive_low: assert property (p_drive_low) else $error("data drive value not low");
  property p_ack_on_low;
    s_ack_up |-> !SCL_I;
  endproperty
  a_ack_on_low: assert property (p_ack_on_low) else $error("pull started with clock high");
  property p_ack_stands;
    s_ack_up |-> SDA_OE_O [*8];
  endproperty
  a_ack_stands: assert property (p_ack_stands) else $error("pull shorter than a clock low");
  property p_steady_high;
    SCL_I && $past(SCL_I) |-> $stable(SDA_OE_O);
  endproperty
  a_steady_high: assert property (p_steady_high) else $error("data changed with clock high");
  property p_conv_min;
    s_conv_up |-> BUSY_O [*8];
  endproperty
  a_conv_min: assert property (p_conv_min) else $error("conversion ended at once");
  property p_conv_max;
    busy_cnt <= MAX_CYC;
  endproperty
  a_conv_max: assert property (p_conv_max) else $error("conversion overran");
  property p_valid_after;
    $rose(RESULT_VALID_O) |-> !BUSY_O && ($past(BUSY_O) || $past(BUSY_O, 2));
  endproperty
  a_valid_after: assert property (p_valid_after) else $error("result without conversion end");
  property p_quiet_reset;
    $rose(RESET_N_I) |-> !BUSY_O && !RESULT_VALID_O && !SDA_OE_O;
  endproperty
  a_quiet_reset: assert property (p_quiet_reset) else $error("outputs active after reset");
endmodule // scm_assertions

bind scm_engine scm_assertions #(.TCONV_4096_NS(TCONV_4096_NS)) i_chk (
  .MCLK_I(MCLK_I), .RESET_N_I(RESET_N_I), .SCL_I(SCL_I), .SDA_O(SDA_O),
  .SDA_OE_O(SDA_OE_O), .BUSY_O(BUSY_O), .RESULT_VALID_O(RESULT_VALID_O));

// >>> dv/scm_ctrl_model.sv
// Purpose: Bus controller model for the two-wire port
// Assumes: 64 ns bit time, data line pulled up
// Notes: Clock stands high between frames
`timescale 1ns/1ps

module scm_ctrl_model (
  output logic scl_o, // Bus clock
  output logic pull_o, // High while pulling data low
  input wire logic sda_i // Resolved data line
);
  initial begin
    scl_o = 1'b1;
    pull_o = 1'b0;
  end
  // One clock, data set while clock is low
  task automatic bit_x(input logic b, output logic r);
    pull_o = ~b;
    #16;
    scl_o = 1'b1;
    #16;
    r = sda_i;
    #16;
    scl_o = 1'b0;
    #16;
  endtask
  // Byte and ninth clock, a is the ninth level
  task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q, output logic ak);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r);
      q[i] = r;
    end
    bit_x(a, r);
    ak = ~r;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] c, output logic ka, output logic kc);
    logic [7:0] q;
    pull_o = 1'b1;
    #16;
    scl_o = 1'b0;
    #16;
    xfer(a, 1'b1, q, ka);
    xfer(c, 1'b1, q, kc);
    stop();
  endtask
  // acknowledge all but the last byte
  task automatic rd(input int n, output logic [23:0] v);
    logic [7:0] q;
    logic ak;
    v = '0;
    pull_o = 1'b1;
    #16;
    scl_o = 1'b0;
    #16;
    xfer(8'hED, 1'b1, q, ak);
    for (int k = 0; k < n; k++) begin
      xfer(8'hFF, k == n - 1, q, ak);
      v = {v[15:0], q};
    end
    stop();
  endtask
  // free a held data line: nine clocks with data released, then stop
  task automatic unstick();
    logic r;
    scl_o = 1'b0;
    #16;
    for (int i = 0; i < 9; i++) begin
      bit_x(1'b1, r);
    end
    stop();
  endtask
  // Stop, then idle with both lines high
  task automatic stop();
    pull_o = 1'b1;
    #16;
    scl_o = 1'b1;
    #16;
    pull_o = 1'b0;
    #32;
  endtask
endmodule // scm_ctrl_model

// >>> dv/test_scm_engine.sv
// Purpose: Self-checking bench of the sensor command engine
// Assumes: Controller model drives the bus
// Notes: Conversion times shortened through parameters
`timescale 1ns/1ps
`include "scm_defs.svh"

module test_scm_engine
  import scm_pkg::*;
();
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  wire scl;
  wire pull;
  logic sda_o, oe, busy, valid, ka, kc;
  wire sda = ~(pull | (oe & ~sda_o)); // Pulled-up data line
  logic [23:0] pres = 24'h0;
  logic [23:0] temp = 24'h0;
  logic [23:0] v;
  scm_cal_t cal = '0;
  int bad_count = 0;
  int checked = 0;
  always #2 mclk = ~mclk;
  scm_ctrl_model i_ctrl (.scl_o(scl), .pull_o(pull), .sda_i(sda));
  scm_engine #(.TCONV_256_NS(400), .TCONV_512_NS(600), .TCONV_1024_NS(800),
    .TCONV_2048_NS(1200), .TCONV_4096_NS(2000)) i_dut (.MCLK_I(mclk), .RESET_N_I(rst_n),
    .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE_O(oe), .PRESSURE_SAMPLE_I(pres),
    .TEMPERATURE_SAMPLE_I(temp), .CAL_MEMORY_I(cal), .BUSY_O(busy), .RESULT_VALID_O(valid));
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t ns: seen %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    if (bad_count == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic wait_idle();
    for (int n = 0; n < 1000 && busy !== 1'b0; n++) begin
      @(posedge mclk);
    end
    check(24'(busy), 24'h0);
  endtask
  task automatic t_idle();
    check(24'({busy, valid, oe}), 24'h0);
    i_ctrl.wr(8'hEC, 8'h00, ka, kc);
    i_ctrl.rd(3, v);
    check(v, 24'h0);
  endtask
  task automatic t_refuse();
    i_ctrl.wr(8'hEE, 8'h48, ka, kc);
    check(24'({ka, kc, busy}), 24'h0);
    i_ctrl.wr(8'hEC, 8'hAE, ka, kc);
    check(24'({ka, kc, busy}), 24'h6);
  endtask
  task automatic t_prom();
    @(posedge mclk);
    #1;
    for (int w = 0; w < 7; w++) begin
      cal[w] = 16'(16'h9A31 * (w + 1));
    end
    i_ctrl.unstick();
    check(24'(oe), 24'h0);
    i_ctrl.wr(8'hEC, 8'h1E, ka, kc);
    for (int w = 0; w < 7; w++) begin
      i_ctrl.wr(8'hEC, 8'(8'hA0 + 2 * w), ka, kc);
      i_ctrl.rd(2, v);
      check(v, 24'(16'(16'h9A31 * (w + 1))));
    end
    @(posedge mclk);
    #1;
    cal[3] = 16'h5AC3;
    i_ctrl.wr(8'hEC, 8'hA6, ka, kc);
    i_ctrl.rd(2, v);
    check(v, 24'(16'(16'h9A31 * 4)));
    i_ctrl.wr(8'hEC, 8'h1E, ka, kc);
    i_ctrl.wr(8'hEC, 8'hA6, ka, kc);
    i_ctrl.rd(2, v);
    check(v, 24'h5AC3);
  endtask
  // every code, one at a time
  task automatic t_conv();
    logic [7:0] c;
    for (int k = 0; k < 10; k++) begin
      c = 8'(8'h40 + (k / 5) * 8'h10 + (k % 5) * 2);
      @(posedge mclk);
      #1;
      pres = {c, 16'hB7E1};
      temp = {~c, 16'h2C49};
      i_ctrl.wr(8'hEC, c, ka, kc);
      check(24'(busy), 24'h1);
      wait_idle();
      check(24'(valid), 24'h1);
      i_ctrl.wr(8'hEC, 8'h00, ka, kc);
      check(24'(valid), 24'h0);
      i_ctrl.rd(3, v);
      check(v, c[4] ? {~c, 16'h2C49} : {c, 16'hB7E1});
      i_ctrl.wr(8'hEC, 8'h00, ka, kc);
      i_ctrl.rd(3, v);
      check(v, 24'h0);
    end
  endtask
  task automatic t_mid();
    i_ctrl.wr(8'hEC, 8'h48, ka, kc);
    i_ctrl.wr(8'hEC, 8'h00, ka, kc);
    i_ctrl.rd(3, v);
    check(v, 24'h0);
    wait_idle();
    i_ctrl.wr(8'hEC, 8'h00, ka, kc);
    i_ctrl.rd(3, v);
    check(v, pres ^ `SCM_CORRUPT_MASK);
  endtask
  initial begin
    repeat (6) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    repeat (8) @(posedge mclk);
    #1;
    t_idle();
    t_refuse();
    t_prom();
    t_conv();
    t_mid();
    close_out();
  end
  initial begin
    #200000;
    bad_count++;
    close_out();
  end
endmodule // test_scm_engine

// >>> hdl/scm_defs.svh
// Purpose: Named constants of the sensor command engine
// Assumes: Included by its bare name from the package and the test bench
// Notes: Definitions only; times are in nanoseconds
`ifndef SCM_DEFS_SVH
`define SCM_DEFS_SVH

// ****************************************************************
// Bus framing
// ****************************************************************
`define SCM_TARGET_ADDR 7'h76
`define SCM_BITS_PER_BYTE 4'h8
`define SCM_LAST_DATA_BIT 4'h7
`define SCM_BIT_CNT_ZERO 4'h0
`define SCM_BIT_CNT_ONE 4'h1

// ****************************************************************
// Command bytes and decode fields
// ****************************************************************
`define SCM_CMD_RESET 8'h1E
`define SCM_CMD_ADC_READ 8'h00
`define SCM_CONV_TOP 3'h2
`define SCM_PROM_TOP 4'hA
`define SCM_RATIO_MAX 3'h4
`define SCM_WORD_MAX 3'h6
`define SCM_CAL_WORDS 7

// ****************************************************************
// Data widths, reset values and masks
// ****************************************************************
`define SCM_RESULT_W 24
`define SCM_WORD_W 16
`define SCM_RESULT_ZERO 24'h000000
`define SCM_PAD_ZERO 8'h00
`define SCM_CORRUPT_MASK 24'h5A5A5A
`define SCM_CNT_ZERO 32'h00000000
`define SCM_CNT_ONE 32'h00000001

// ****************************************************************
// Conversion times per ratio, clock period
// ****************************************************************
`define SCM_TCONV_256_NS 540000
`define SCM_TCONV_512_NS 1060000
`define SCM_TCONV_1024_NS 2080000
`define SCM_TCONV_2048_NS 4130000
`define SCM_TCONV_4096_NS 8220000
`define SCM_MCLK_PERIOD_NS 4

`endif

// >>> hdl/scm_engine.sv
// Purpose: Command interpreter of a pressure/temperature sensor behind a two-wire target port
// Assumes: Bus clock arrives on SCL_I; converter samples and calibration image come in on ports
// Notes: Link logic runs on SCL_I; all of it but the command handover is held cleared outside frames by the core domain
`timescale 1ns/1ps

module scm_engine
  import scm_pkg::*;
#(
  parameter int TCONV_256_NS = `SCM_TCONV_256_NS,    // Conversion time at ratio 256
  parameter int TCONV_512_NS = `SCM_TCONV_512_NS,    // Conversion time at ratio 512
  parameter int TCONV_1024_NS = `SCM_TCONV_1024_NS,  // Conversion time at ratio 1024
  parameter int TCONV_2048_NS = `SCM_TCONV_2048_NS,  // Conversion time at ratio 2048
  parameter int TCONV_4096_NS = `SCM_TCONV_4096_NS   // Conversion time at ratio 4096
) (
  input wire logic MCLK_I,                                  // Core clock, 250 MHz
  input wire logic RESET_N_I,                               // Async reset, active low
  input wire logic SCL_I,                                   // Bus clock from controller
  input wire logic SDA_I,                                   // Data line level
  output logic SDA_O,                                       // Data line drive value, always low
  output logic SDA_OE_O,                                    // High while pulling data line low
  input wire logic [`SCM_RESULT_W-1:0] PRESSURE_SAMPLE_I,   // Converter pressure value
  input wire logic [`SCM_RESULT_W-1:0] TEMPERATURE_SAMPLE_I, // Converter temperature value
  input wire scm_cal_t CAL_MEMORY_I,                        // Factory calibration memory
  output logic BUSY_O,                                      // Conversion running
  output logic RESULT_VALID_O                               // Unread result held
);

  // ****************************************************************
  // Conversion cycle counts
  // ****************************************************************
  localparam int CYC_256 = TCONV_256_NS / `SCM_MCLK_PERIOD_NS;   // Cycles at ratio 256
  localparam int CYC_512 = TCONV_512_NS / `SCM_MCLK_PERIOD_NS;   // Cycles at ratio 512
  localparam int CYC_1024 = TCONV_1024_NS / `SCM_MCLK_PERIOD_NS; // Cycles at ratio 1024
  localparam int CYC_2048 = TCONV_2048_NS / `SCM_MCLK_PERIOD_NS; // Cycles at ratio 2048
  localparam int CYC_4096 = TCONV_4096_NS / `SCM_MCLK_PERIOD_NS; // Cycles at ratio 4096

  // Remaining cycles to load for a ratio code, one less than the conversion length, at least zero
  function automatic logic [31:0] conv_load(input logic [2:0] ratio);
    int cyc;
    case (ratio)
      3'h0: cyc = CYC_256;
      3'h1: cyc = CYC_512;
      3'h2: cyc = CYC_1024;
      3'h3: cyc = CYC_2048;
      default: cyc = CYC_4096;
    endcase
    if (cyc < 1) begin
      cyc = 1;
    end
    return 32'(cyc - 1);
  endfunction

  // ****************************************************************
  // Core reset release and pin synchronisers
  // ****************************************************************
  logic [1:0] rst_pipe; // Reset release chain
  logic rst_n;          // Released core reset
  logic scl_meta;       // First stage, bus clock
  logic scl_s;          // Synchronised bus clock
  logic scl_d;          // Previous bus clock
  logic sda_meta;       // First stage, data
  logic sda_s;          // Synchronised data
  logic sda_d;          // Previous data

  // Two-stage release of the external reset
  always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe[1];

  // Bus lines into the core domain
  always_ff @(posedge MCLK_I or negedge rst_n) begin
    if (!rst_n) begin
      scl_meta <= 1'b1;
      scl_s <= 1'b1;
      scl_d <= 1'b1;
      sda_meta <= 1'b1;
      sda_s <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_meta <= SCL_I;
      scl_s <= scl_meta;
      scl_d <= scl_s;
      sda_meta <= SDA_I;
      sda_s <= sda_meta;
      sda_d <= sda_s;
    end
  end

  // ****************************************************************
  // Frame tracking, clears link phase, shifters and data drive outside frames
  // ****************************************************************
  logic start_seen;   // Data falls while clock high
  logic stop_seen;    // Data rises while clock high
  logic bus_busy;     // Inside a frame
  logic hold;         // Start seen, clock not yet low
  logic link_clear_n; // Releases link logic
  logic next_bus_busy;
  logic next_hold;
  logic next_link_clear_n;

  assign start_seen = scl_s && scl_d && sda_d && !sda_s;
  assign stop_seen = scl_s && scl_d && !sda_d && sda_s;

  // Release only while the bus clock is low, so no edge races it
  always_comb begin
    next_bus_busy = bus_busy;
    next_hold = hold;
    if (start_seen) begin
      // New or repeated start restarts the byte framing
      next_bus_busy = 1'b1;
      next_hold = 1'b1;
    end else if (stop_seen) begin
      next_bus_busy = 1'b0;
    end else if (!scl_s) begin
      next_hold = 1'b0;
    end
    next_link_clear_n = next_bus_busy && !next_hold;
  end

  always_ff @(posedge MCLK_I or negedge rst_n) begin
    if (!rst_n) begin
      bus_busy <= 1'b0;
      hold <= 1'b0;
      link_clear_n <= 1'b0;
    end else begin
      bus_busy <= next_bus_busy;
      hold <= next_hold;
      link_clear_n <= next_link_clear_n;
    end
  end

  // ****************************************************************
  // Link receive/transmit, bus clock rising edge
  // ****************************************************************
  scm_link_t phase;                  // Transaction phase
  logic [3:0] bit_cnt;               // Bits of current byte, 8 = acknowledge slot
  logic [7:0] rx_shift;              // Received bits
  logic [`SCM_RESULT_W-1:0] tx_shift; // Bits still to send, top first
  scm_cmd_t cmd_byte;                // Last command byte, stable for the core
  logic cmd_tog;                     // Flips once per command byte
  logic [`SCM_RESULT_W-1:0] out_word; // Armed answer, core domain
  scm_link_t next_phase;
  logic [3:0] next_bit_cnt;
  logic [7:0] next_rx_shift;
  logic [`SCM_RESULT_W-1:0] next_tx_shift;
  scm_cmd_t next_cmd_byte;
  logic next_cmd_tog;
  logic addr_match;                  // Address byte names this target

  assign addr_match = (rx_shift[7:1] == `SCM_TARGET_ADDR);

  always_comb begin
    next_phase = phase;
    next_bit_cnt = bit_cnt;
    next_rx_shift = rx_shift;
    next_tx_shift = tx_shift;
    next_cmd_byte = cmd_byte;
    next_cmd_tog = cmd_tog;
    case (phase)
      LINK_ADDR: begin
        if (bit_cnt < `SCM_BITS_PER_BYTE) begin
          next_rx_shift = {rx_shift[6:0], SDA_I};
          next_bit_cnt = bit_cnt + `SCM_BIT_CNT_ONE;
        end else if (addr_match && rx_shift[0]) begin
          // armed word goes out, read direction
          next_tx_shift = out_word;
          next_phase = LINK_READ;
          next_bit_cnt = `SCM_BIT_CNT_ZERO;
        end else if (addr_match) begin
          next_phase = LINK_WRITE;
          next_bit_cnt = `SCM_BIT_CNT_ZERO;
        end else begin
          // Other target, stay silent
          next_phase = LINK_IGNORE;
        end
      end
      LINK_WRITE: begin
        if (bit_cnt < `SCM_BITS_PER_BYTE) begin
          next_rx_shift = {rx_shift[6:0], SDA_I};
          next_bit_cnt = bit_cnt + `SCM_BIT_CNT_ONE;
          if (bit_cnt == `SCM_LAST_DATA_BIT) begin
            // full byte handed to the core
            next_cmd_byte = scm_cmd_t'({rx_shift[6:0], SDA_I});
            next_cmd_tog = !cmd_tog;
          end
        end else begin
          next_phase = LINK_IGNORE;
        end
      end
      LINK_READ: begin
        if (bit_cnt < `SCM_BITS_PER_BYTE) begin
          // shift out most significant bit first
          next_tx_shift = {tx_shift[`SCM_RESULT_W-2:0], 1'b0};
          next_bit_cnt = bit_cnt + `SCM_BIT_CNT_ONE;
        end else if (SDA_I) begin
          // Not acknowledged, transfer over
          next_phase = LINK_IGNORE;
        end else begin
          next_bit_cnt = `SCM_BIT_CNT_ZERO;
        end
      end
      LINK_IGNORE: begin
        next_phase = LINK_IGNORE;
      end
      default: begin
        next_phase = LINK_IGNORE;
      end
    endcase
  end

  always_ff @(posedge SCL_I or negedge link_clear_n) begin
    if (!link_clear_n) begin
      phase <= LINK_ADDR;
      bit_cnt <= `SCM_BIT_CNT_ZERO;
      rx_shift <= 8'h00;
      tx_shift <= `SCM_RESULT_ZERO;
    end else begin
      phase <= next_phase;
      bit_cnt <= next_bit_cnt;
      rx_shift <= next_rx_shift;
      tx_shift <= next_tx_shift;
    end
  end

  // Command handover survives frame clears, only core reset clears it
  always_ff @(posedge SCL_I or negedge rst_n) begin
    if (!rst_n) begin
      cmd_byte <= scm_cmd_t'(8'h00);
      cmd_tog <= 1'b0;
    end else begin
      cmd_byte <= next_cmd_byte;
      cmd_tog <= next_cmd_tog;
    end
  end

  // ****************************************************************
  // Data line drive, bus clock falling edge
  // ****************************************************************
  logic sda_pull;      // Pull data line low
  logic next_sda_pull;

  always_comb begin
    next_sda_pull = 1'b0;
    case (phase)
      LINK_ADDR: begin
        next_sda_pull = (bit_cnt == `SCM_BITS_PER_BYTE) && addr_match;
      end
      LINK_WRITE: begin
        next_sda_pull = (bit_cnt == `SCM_BITS_PER_BYTE);
      end
      LINK_READ: begin
        next_sda_pull = (bit_cnt < `SCM_BITS_PER_BYTE) && !tx_shift[`SCM_RESULT_W-1];
      end
      default: begin
        next_sda_pull = 1'b0;
      end
    endcase
  end

  always_ff @(negedge SCL_I or negedge link_clear_n) begin
    if (!link_clear_n) begin
      sda_pull <= 1'b0;
    end else begin
      sda_pull <= next_sda_pull;
    end
  end

  assign SDA_OE_O = sda_pull;
  assign SDA_O = 1'b0;

  // ****************************************************************
  // Command arrival in the core domain
  // ****************************************************************
  logic tog_meta;   // First stage of command toggle
  logic tog_s;      // Synchronised toggle
  logic tog_d;      // Previous toggle
  logic cmd_strobe; // One cycle per command byte

  always_ff @(posedge MCLK_I or negedge rst_n) begin
    if (!rst_n) begin
      tog_meta <= 1'b0;
      tog_s <= 1'b0;
      tog_d <= 1'b0;
    end else begin
      tog_meta <= cmd_tog;
      tog_s <= tog_meta;
      tog_d <= tog_s;
    end
  end
  assign cmd_strobe = tog_s ^ tog_d;

  // ****************************************************************
  // Command interpreter and converter sequencing
  // ****************************************************************
  scm_eng_t state;                 // Converter state
  logic [31:0] conv_cnt;           // Cycles left in conversion
  logic conv_temp;                 // Running conversion is temperature
  logic corrupt;                   // Running conversion was disturbed
  logic [`SCM_RESULT_W-1:0] result; // Last finished conversion
  logic result_valid;              // Result not yet armed for read
  scm_cal_t cal_hold;              // Calibration holding register
  scm_eng_t next_state;
  logic [31:0] next_conv_cnt;
  logic next_conv_temp;
  logic next_corrupt;
  logic [`SCM_RESULT_W-1:0] next_result;
  logic next_result_valid;
  logic [`SCM_RESULT_W-1:0] next_out_word;
  scm_cal_t next_cal_hold;
  logic is_conv;                   // Decoded conversion command
  logic is_prom;                   // Decoded calibration read command

  assign is_conv = (cmd_byte[7:5] == `SCM_CONV_TOP) && !cmd_byte.stop_bit &&
                   (cmd_byte.word_index_or_ratio <= `SCM_RATIO_MAX);
  assign is_prom = (cmd_byte[7:4] == `SCM_PROM_TOP) && !cmd_byte.stop_bit &&
                   (cmd_byte.word_index_or_ratio <= `SCM_WORD_MAX);

  always_comb begin
    next_state = state;
    next_conv_cnt = conv_cnt;
    next_conv_temp = conv_temp;
    next_corrupt = corrupt;
    next_result = result;
    next_result_valid = result_valid;
    next_out_word = out_word;
    next_cal_hold = cal_hold;
    case (state)
      ENG_CONVERTING: begin
        if (conv_cnt == `SCM_CNT_ZERO) begin
          // end of conversion, 24-bit value held
          next_result = (conv_temp ? TEMPERATURE_SAMPLE_I : PRESSURE_SAMPLE_I) ^
                        (corrupt ? `SCM_CORRUPT_MASK : `SCM_RESULT_ZERO);
          next_result_valid = 1'b1;
          next_state = ENG_IDLE;
        end else begin
          next_conv_cnt = conv_cnt - `SCM_CNT_ONE;
        end
      end
      ENG_IDLE: begin
        next_state = ENG_IDLE;
      end
      default: begin
        next_state = ENG_IDLE;
      end
    endcase
    if (cmd_strobe) begin
      if (cmd_byte == scm_cmd_t'(`SCM_CMD_RESET)) begin
        next_state = ENG_IDLE;
        next_corrupt = 1'b0;
        next_result = `SCM_RESULT_ZERO;
        next_result_valid = 1'b0;
        next_out_word = `SCM_RESULT_ZERO;
        next_cal_hold = CAL_MEMORY_I;
      end else if (cmd_byte == scm_cmd_t'(`SCM_CMD_ADC_READ)) begin
        next_out_word = (result_valid && state == ENG_IDLE) ? result : `SCM_RESULT_ZERO;
        next_result_valid = 1'b0;
        if (state == ENG_CONVERTING) begin
          next_corrupt = 1'b1;
        end
      end else if (is_conv) begin
        next_corrupt = (state == ENG_CONVERTING);
        next_state = ENG_CONVERTING;
        next_conv_cnt = conv_load(cmd_byte.word_index_or_ratio);
        next_conv_temp = cmd_byte.measurand_type_bit;
        next_result_valid = 1'b0;
      end else if (is_prom) begin
        // calibration word, check code passes through
        next_out_word = {cal_hold[cmd_byte.word_index_or_ratio], `SCM_PAD_ZERO};
      end
    end
  end

  always_ff @(posedge MCLK_I or negedge rst_n) begin
    if (!rst_n) begin
      state <= ENG_IDLE;
      conv_cnt <= `SCM_CNT_ZERO;
      conv_temp <= 1'b0;
      corrupt <= 1'b0;
      result <= `SCM_RESULT_ZERO;
      result_valid <= 1'b0;
      out_word <= `SCM_RESULT_ZERO;
      cal_hold <= '0;
    end else begin
      state <= next_state;
      conv_cnt <= next_conv_cnt;
      conv_temp <= next_conv_temp;
      corrupt <= next_corrupt;
      result <= next_result;
      result_valid <= next_result_valid;
      out_word <= next_out_word;
      cal_hold <= next_cal_hold;
    end
  end

  assign BUSY_O = (state == ENG_CONVERTING);
  assign RESULT_VALID_O = result_valid;

endmodule // scm_engine

// >>> hdl/scm_pkg.sv
// Purpose: Types shared by the sensor command engine
// Assumes: Constants come from scm_defs.svh
// Notes: Command byte bit 7 is the first bit on the wire
`include "scm_defs.svh"

package scm_pkg;

  // ****************************************************************
  // Command byte layout, first wire bit on top
  // ****************************************************************
  typedef struct packed {
    logic memory_read_select_bit;   // Selects calibration memory read
    logic conversion_select_bit;    // Selects a conversion
    logic spare_bit;                // Set in memory read commands
    logic measurand_type_bit;       // Temperature when set
    logic [2:0] word_index_or_ratio; // Word index or ratio code
    logic stop_bit;                 // Always zero
  } scm_cmd_t;

  // Calibration memory image, word 0 holds the check code on top
  typedef logic [`SCM_CAL_WORDS-1:0][`SCM_WORD_W-1:0] scm_cal_t;

  // Link phase within one transaction
  typedef enum logic [1:0] {
    LINK_ADDR,
    LINK_WRITE,
    LINK_READ,
    LINK_IGNORE
  } scm_link_t;

  // Converter state
  typedef enum logic {
    ENG_IDLE,
    ENG_CONVERTING
  } scm_eng_t;

endpackage : scm_pkg
